// ==== hdl/svwrg_pkg.sv ====
// Constants shared by the supervisor watchdog and reset gate.
package svwrg_pkg;
    // Core clock rate.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    // Internal timebase periods in milliseconds.
    localparam int unsigned RST_TIMEOUT_MS = 200;
    localparam int unsigned WD_LONG_MS = 1600;
    localparam int unsigned WD_SHORT_MS = 100;
    // Internal timebase periods in clock cycles.
    localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * CLK_PER_MS;
    localparam int unsigned WD_LONG_CYC = WD_LONG_MS * CLK_PER_MS;
    localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CLK_PER_MS;
    // External timebase periods in timebase clocks.
    localparam int unsigned EXT_RST_CLKS = 2048;
    localparam int unsigned EXT_WD_NORM_CLKS = 1024;
    localparam int unsigned EXT_WD_FIRST_CLKS = 4096;
    // Chip-enable grace window after reset asserts, longest time, rounded down.
    localparam int unsigned CE_GRACE_NS = 15000;
    localparam int unsigned CE_GRACE_CYC = CE_GRACE_NS * (CLK_HZ / 1_000_000) / 1000;
    // Counter widths.
    localparam int CNT_W = 28;
    localparam int GATE_W = 10;
    // Bus geometry and register offsets.
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADR_W-1:0] COUNT_OFS = 8'h08;
    // Control field position and reset value.
    localparam int CTRL_WD_EN_BIT = 0;
    localparam logic CTRL_WD_EN_RST = 1'b1;
    // Status field positions.
    localparam int ST_RESET_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_WDOFF_BIT = 2;
    localparam int ST_EXT_BIT = 3;
    localparam int ST_FIRST_BIT = 4;
    localparam int ST_LOW_BIT = 5;
    localparam int ST_BACKUP_BIT = 6;
    localparam int ST_CEPASS_BIT = 7;
    // Supervisor states.
    typedef enum logic [1:0] {
        SVWRG_HOLD = 2'b01,
        SVWRG_WATCH = 2'b10
    } svwrg_state_e;
endpackage : svwrg_pkg

// ==== hdl/svwrg_top.sv ====
// Supervisor with reset stretcher, watchdog, chip-enable gate and register slave.
// Functional notes
// - Reset held while supply low, then stretched by the reset timeout.
// - Reset follows supply-low, backup switchover and watchdog; backup mode implies reset.
// - Kick input idle past watchdog timeout raises fault and both resets.
// - Any kick edge or short pulse restarts the watchdog timer.
// - Floating mid-level kick input disables the watchdog entirely.
// - Watchdog off and fault output high in supply-low, backup or float.
// - Timeout gives a reset pulse; fault stays low until next kick edge.
// - Without kicks, reset pulses repeat, one watchdog interval apart.
// - Internal source, timing input high: 1.6 s watchdog, 200 ms reset.
// - Internal source, timing input low: 100 ms normal, 1.6 s after reset.
// - External clock: 1024 normal, 4096 after reset, 2048 reset clocks.
// - Chip-enable passes in normal operation and is blocked during reset once the gate closes.
// - While reset asserted, chip-enable input drives the output only until the gate closes.
// - Disabled chip-enable output driven high; pull-up released when passing.
// - On reset, gate closes at input high or after 15 us, first wins.
// - At power-up the gate stays closed until reset timeout ends.
// - Active-low reset and active-high open-drain reset are inverses.
// - Early-warning comparator drives only its own flag.
// - Low-line flag follows the supply-low indication with no stretch.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module svwrg_top
    import svwrg_pkg::*;
#(
    parameter int unsigned RST_CYCLES = RST_TIMEOUT_CYC,
    parameter int unsigned WD_LONG_CYCLES = WD_LONG_CYC,
    parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Supply monitor and backup switchover.
    input wire logic SUPPLY_LOW,
    input wire logic BACKUP_SWITCHED,
    output logic LOW_LINE_N,
    output logic BACKUP_ACTIVE_FLAG,
    // Early-warning comparator.
    input wire logic EARLY_WARNING_SENSE,
    output logic EARLY_WARNING_FLAG,
    // Watchdog kick input and fault output.
    input wire logic KICK_INPUT,
    input wire logic KICK_INPUT_FLOAT,
    output logic KICK_FAULT_OUTPUT,
    // Timebase straps.
    input wire logic TIMEBASE_SOURCE_STRAP,
    input wire logic TIMEBASE_TIMING_INPUT,
    // Reset outputs.
    output logic RESET_N,
    output logic RESET_HI_O,
    output logic RESET_HI_OE,
    // Chip-enable gate.
    input wire logic CE_IN_N,
    output logic CE_OUT_N,
    output logic CE_PULLUP,
    // Wishbone slave.
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [DAT_W-1:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O
);

    svwrg_state_e state_reg;
    svwrg_state_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic first_reg;
    logic first_next;
    logic fault_reg;
    logic fault_next;
    logic low_reg;
    logic backup_reg;
    logic warn_reg;
    logic src_reg;
    logic kick_s1_reg;
    logic kick_s2_reg;
    logic kick_s3_reg;
    logic mid_s1_reg;
    logic mid_s2_reg;
    logic tim_s1_reg;
    logic tim_s2_reg;
    logic tim_s3_reg;
    logic ce_pass_reg;
    logic ce_pass_next;
    logic [GATE_W-1:0] gate_reg;
    logic wd_en_reg;
    logic ack_reg;
    logic [DAT_W-1:0] dat_reg;

    // Input stages; first synchroniser flops feed only the second.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_reg <= 1'b1;
            backup_reg <= 1'b0;
            warn_reg <= 1'b0;
            src_reg <= 1'b1;
            kick_s1_reg <= 1'b0;
            kick_s2_reg <= 1'b0;
            kick_s3_reg <= 1'b0;
            mid_s1_reg <= 1'b1;
            mid_s2_reg <= 1'b1;
            tim_s1_reg <= 1'b1;
            tim_s2_reg <= 1'b1;
            tim_s3_reg <= 1'b1;
        end else begin
            low_reg <= SUPPLY_LOW;
            backup_reg <= BACKUP_SWITCHED;
            warn_reg <= EARLY_WARNING_SENSE;
            src_reg <= TIMEBASE_SOURCE_STRAP;
            kick_s1_reg <= KICK_INPUT;
            kick_s2_reg <= kick_s1_reg;
            kick_s3_reg <= kick_s2_reg;
            mid_s1_reg <= KICK_INPUT_FLOAT;
            mid_s2_reg <= mid_s1_reg;
            tim_s1_reg <= TIMEBASE_TIMING_INPUT;
            tim_s2_reg <= tim_s1_reg;
            tim_s3_reg <= tim_s2_reg;
        end
    end

    // Derived conditions.
    logic sup_fail;
    logic wd_off;
    logic kick_edge;
    logic ext_mode;
    logic tick;
    logic reset_active;
    assign sup_fail = low_reg | backup_reg;
    assign wd_off = sup_fail | mid_s2_reg | ~wd_en_reg;
    assign kick_edge = kick_s2_reg ^ kick_s3_reg;
    assign ext_mode = ~src_reg;
    // In external mode the counter advances on each timebase clock rise.
    assign tick = ext_mode ? (tim_s2_reg & ~tim_s3_reg) : 1'b1;
    assign reset_active = (state_reg == SVWRG_HOLD);

    // Limit selection for the active interval.
    logic [CNT_W-1:0] rst_lim;
    logic [CNT_W-1:0] norm_lim;
    logic [CNT_W-1:0] first_lim;
    logic [CNT_W-1:0] lim_w;
    logic expire;
    assign rst_lim = ext_mode ? CNT_W'(EXT_RST_CLKS) : CNT_W'(RST_CYCLES);
    // short normal interval when timing input low.
    assign norm_lim = ext_mode ? CNT_W'(EXT_WD_NORM_CLKS)
                    : (tim_s2_reg ? CNT_W'(WD_LONG_CYCLES) : CNT_W'(WD_SHORT_CYCLES));
    assign first_lim = ext_mode ? CNT_W'(EXT_WD_FIRST_CLKS) : CNT_W'(WD_LONG_CYCLES);
    assign lim_w = reset_active ? rst_lim : (first_reg ? first_lim : norm_lim);
    assign expire = tick & (cnt_reg == lim_w - CNT_W'(1));

    // Supervisor next-state logic.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        first_next = first_reg;
        fault_next = fault_reg;
        if (sup_fail) begin
            state_next = SVWRG_HOLD;
            cnt_next = '0;
            fault_next = 1'b0;
        end else begin
            unique case (state_reg)
                SVWRG_HOLD: begin
                    if (kick_edge) begin
                        fault_next = 1'b0;
                    end
                    if (expire) begin
                        state_next = SVWRG_WATCH;
                        cnt_next = '0;
                        first_next = 1'b1;
                    end else if (tick) begin
                        cnt_next = cnt_reg + CNT_W'(1);
                    end
                end
                SVWRG_WATCH: begin
                    if (wd_off) begin
                        cnt_next = '0;
                    end else if (kick_edge) begin
                        cnt_next = '0;
                        first_next = 1'b0;
                        fault_next = 1'b0;
                    end else if (expire) begin
                        state_next = SVWRG_HOLD;
                        cnt_next = '0;
                        fault_next = 1'b1;
                    end else if (tick) begin
                        cnt_next = cnt_reg + CNT_W'(1);
                    end
                end
                default: begin
                    state_next = SVWRG_HOLD;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // Supervisor state registers.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= SVWRG_HOLD;
            cnt_reg <= '0;
            first_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            first_reg <= first_next;
            fault_reg <= fault_next;
        end
    end

    // Chip-enable gate; closes at input high or end of grace window.
    logic grace_open;
    assign grace_open = (gate_reg < GATE_W'(CE_GRACE_CYC - 1));
    assign ce_pass_next = reset_active ? (ce_pass_reg & ~CE_IN_N & grace_open) : 1'b1;

    // Gate registers; the gate starts closed out of reset.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ce_pass_reg <= 1'b0;
            gate_reg <= '0;
        end else begin
            ce_pass_reg <= ce_pass_next;
            if (!reset_active) begin
                gate_reg <= '0;
            end else if (grace_open) begin
                gate_reg <= gate_reg + GATE_W'(1);
            end
        end
    end

    // Pin outputs.
    // pass path when open.
    assign CE_OUT_N = ce_pass_reg ? CE_IN_N : 1'b1;
    assign CE_PULLUP = ~ce_pass_reg;
    assign RESET_N = ~reset_active;
    assign RESET_HI_O = 1'b0;
    assign RESET_HI_OE = ~reset_active;
    assign KICK_FAULT_OUTPUT = ~(fault_reg & ~wd_off);
    assign LOW_LINE_N = ~low_reg;
    assign BACKUP_ACTIVE_FLAG = backup_reg;
    assign EARLY_WARNING_FLAG = warn_reg;

    // Wishbone decode.
    logic bus_req;
    logic hit_ctrl;
    logic [DAT_W-1:0] status_w;
    logic [DAT_W-1:0] rd_w;
    logic wr_ctrl;
    assign bus_req = WB_CYC_I & WB_STB_I & ~ack_reg;
    // A control write lands only at the edge where the master samples acknowledge.
    assign wr_ctrl = ack_reg & WB_CYC_I & WB_STB_I & WB_WE_I & hit_ctrl & WB_SEL_I[0];
    assign hit_ctrl = (WB_ADR_I == CTRL_OFS);
    assign status_w = DAT_W'({ce_pass_reg, backup_reg, low_reg, first_reg,
                              ext_mode, wd_off, fault_reg, reset_active});
    assign rd_w = hit_ctrl ? DAT_W'(wd_en_reg)
                : (WB_ADR_I == STATUS_OFS) ? status_w
                : (WB_ADR_I == COUNT_OFS) ? DAT_W'(cnt_reg)
                : 32'h0000_0000;
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // Bus slave; one wait cycle, unmapped reads give zero.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            wd_en_reg <= CTRL_WD_EN_RST;
        end else begin
            ack_reg <= bus_req;
            if (bus_req && !WB_WE_I) begin
                dat_reg <= rd_w;
            end
            if (wr_ctrl) begin
                wd_en_reg <= WB_DAT_I[CTRL_WD_EN_BIT];
            end
        end
    end

    // Checks.
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // Multi-step behaviours as named sequences.
    sequence rst_rise_s;
        !reset_active ##1 reset_active;
    endsequence
    sequence hold_end_s;
        reset_active ##1 !reset_active;
    endsequence
    sequence fault_idle_s;
        !KICK_FAULT_OUTPUT && !kick_edge ##1 !wd_off;
    endsequence

    // Reset and watchdog checks.
    low_reset_a: assert property (low_reg |=> reset_active)
        else $error("reset not held while supply low");
    backup_reset_a: assert property (backup_reg |=> reset_active && !RESET_N)
        else $error("reset not asserted in backup mode");
    timeout_fault_a: assert property (!sup_fail && !wd_off && !reset_active && !kick_edge && expire
        |=> reset_active && !KICK_FAULT_OUTPUT)
        else $error("watchdog expiry did not fault");
    kick_restart_a: assert property (!sup_fail && !wd_off && !reset_active && kick_edge
        |=> cnt_reg == '0 && !reset_active)
        else $error("kick did not restart timer");
    float_off_a: assert property (mid_s2_reg && !reset_active && !sup_fail
        |=> cnt_reg == '0 && !reset_active)
        else $error("float did not stop watchdog");
    fault_high_a: assert property (wd_off |-> KICK_FAULT_OUTPUT)
        else $error("fault output low while watchdog off");
    fault_clear_a: assert property (!KICK_FAULT_OUTPUT && kick_edge && !sup_fail
        |=> KICK_FAULT_OUTPUT)
        else $error("fault not cleared by kick");
    first_long_a: assert property (hold_end_s |-> first_reg && cnt_reg == '0)
        else $error("after-reset interval not long");

    // Chip-enable gate checks.
    ce_block_a: assert property (reset_active && !ce_pass_reg |-> CE_OUT_N && CE_PULLUP)
        else $error("chip-enable driven during reset");
    ce_pull_a: assert property (ce_pass_reg |-> !CE_PULLUP && CE_OUT_N == CE_IN_N)
        else $error("pull-up active while gate passes");
    gate_stay_a: assert property (reset_active && !ce_pass_reg |=> !ce_pass_reg)
        else $error("gate reopened during reset");
    ce_grace_a: assert property (rst_rise_s ##1 (reset_active && CE_IN_N)[*2] |-> !ce_pass_reg)
        else $error("gate open after input high");
    ce_bound_a: assert property (reset_active && gate_reg == GATE_W'(CE_GRACE_CYC - 1) |=> !ce_pass_reg)
        else $error("gate open past grace window");
    ce_open_a: assert property (!reset_active [*2] |-> ce_pass_reg && !CE_PULLUP)
        else $error("gate closed in normal operation");

    // Pin and flag checks.
    reset_inv_a: assert property (RESET_HI_OE == RESET_N && !RESET_HI_O)
        else $error("reset outputs not complementary");
    low_line_a: assert property ($past(RST_N) |-> LOW_LINE_N == !$past(SUPPLY_LOW))
        else $error("low line not following supply");
    warn_flag_a: assert property ($past(RST_N) |-> EARLY_WARNING_FLAG == $past(EARLY_WARNING_SENSE))
        else $error("early-warning flag not following its input");
    kick_sync_a: assert property (
        $past(RST_N, 3) && kick_edge |-> $past(KICK_INPUT, 2) != $past(KICK_INPUT, 3))
        else $error("kick edge without a synced pin change");
    ext_count_a: assert property (
        ext_mode && !tick && !sup_fail && !kick_edge && !wd_off |=> $stable(cnt_reg))
        else $error("external count moved without a timebase rise");
    fault_stay_a: assert property (fault_idle_s |-> !KICK_FAULT_OUTPUT)
        else $error("fault released without a kick");

endmodule : svwrg_top

// ==== verification/svwrg_host_model.sv ====
// Host processor model that drives the watchdog kick line.
`timescale 1ns/1ps
module svwrg_host_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Kick pacing.
    input wire logic run,
    input wire logic [5:0] half_per,
    // Kick line.
    output logic kick
);
    logic [5:0] cnt_reg;
    // host kick activity
    // Toggles the kick line every half_per plus one cycles while running, and holds it otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
            kick <= 1'b0;
        end else if (run && cnt_reg >= half_per) begin
            cnt_reg <= 6'h00;
            kick <= ~kick;
        end else if (run) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end
endmodule : svwrg_host_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the supervisor watchdog and reset gate.
`timescale 1ns/1ps
module tb_top
    import svwrg_pkg::*;
;
    localparam int P_RST = 40;
    localparam int P_LONG = 200;
    localparam int P_SHORT = 60;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic rst_n, supply_low, backup, ews, kfloat, src_strap, timing_lvl, ce_in_n, run, ext_run, ew_prev;
    logic wb_we, wb_cyc, wb_stb, wb_ack, low_line_n, backup_flag, ew_flag, kick, fault;
    logic reset_n, rst_hi_o, rst_hi_oe, ce_out_n, ce_pullup;
    logic [5:0] half;
    logic [1:0] ext_div;
    logic [3:0] wb_sel;
    logic [ADR_W-1:0] wb_adr;
    logic [DAT_W-1:0] wb_wd, wb_rd, rd;
    int mismatches, cmp_count, cyc, rises, n, r0, i;
    wire timing = src_strap ? timing_lvl : ext_div[1];

    svwrg_top #(.RST_CYCLES(P_RST), .WD_LONG_CYCLES(P_LONG), .WD_SHORT_CYCLES(P_SHORT)) i_dut (
        .REF_CLK(clk), .RST_N(rst_n), .SUPPLY_LOW(supply_low), .BACKUP_SWITCHED(backup),
        .LOW_LINE_N(low_line_n), .BACKUP_ACTIVE_FLAG(backup_flag), .EARLY_WARNING_SENSE(ews),
        .EARLY_WARNING_FLAG(ew_flag), .KICK_INPUT(kick), .KICK_INPUT_FLOAT(kfloat),
        .KICK_FAULT_OUTPUT(fault), .TIMEBASE_SOURCE_STRAP(src_strap), .TIMEBASE_TIMING_INPUT(timing),
        .RESET_N(reset_n), .RESET_HI_O(rst_hi_o), .RESET_HI_OE(rst_hi_oe), .CE_IN_N(ce_in_n),
        .CE_OUT_N(ce_out_n), .CE_PULLUP(ce_pullup), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_wd),
        .WB_SEL_I(wb_sel), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
        .WB_DAT_O(wb_rd), .WB_ACK_O(wb_ack));

    svwrg_host_model i_host (.clk(clk), .rst_n(rst_n), .run(run), .half_per(half), .kick(kick));

    // Core clock at 50 MHz.
    always #10 clk = ~clk;

    // Divides the core clock by four to make the external timebase.
    always @(posedge clk) begin
        if (ext_run) begin
            ext_div <= ext_div + 2'h1;
        end
    end

    // Counts external timebase rises.
    always @(posedge timing) begin
        rises++;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc++;
        if (cyc >= LIMIT) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk

    // Timed counts allow for the synchroniser and register latency.
    task automatic chk_win(input string what, input int exp, input int got);
        cmp_count++;
        if (got < exp - 2 || got > exp + 6) begin
            mismatches++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : chk_win

    function automatic int wd_cycles(input logic first, input logic t_low);
        return (first || !t_low) ? P_LONG : P_SHORT;
    endfunction : wd_cycles

    task automatic wait_rst(input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (reset_n !== lvl && cnt < max) begin
            @(posedge clk);
            cnt++;
        end
    endtask : wait_rst

    // One classic Wishbone cycle, held until acknowledge is sampled.
    task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] wd,
                           output logic [DAT_W-1:0] rdat);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wd <= wd;
        wb_sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        rdat = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer

    // Main sequence.
    initial begin
        void'($urandom(61));
        {rst_n, supply_low, backup, ews, kfloat, ce_in_n, run, ext_run, ew_prev} = '0;
        {wb_we, wb_cyc, wb_stb, src_strap, timing_lvl} = 5'h03;
        half = 6'h08;
        ext_div = 2'h0;
        wb_sel = 4'h0;
        wb_adr = '0;
        wb_wd = '0;
        {mismatches, cmp_count, cyc, rises} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("ce_out_n", 1'b1, ce_out_n);
        chk("ce_pullup", 1'b1, ce_pullup);
        chk("rst_hi_oe", 1'b0, rst_hi_oe);
        wait_rst(1'b1, 200, n);
        chk_win("power-up stretch", P_RST, n + 20);
        run <= 1'b1;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            chk("ce_out_n", ce_in_n, ce_out_n);
            chk("ce_pullup", 1'b0, ce_pullup);
            chk("ew_flag", ew_prev, ew_flag);
            chk("reset_n", 1'b1, reset_n);
            chk("rst_hi_oe", 1'b1, rst_hi_oe);
            ew_prev = ews;
            ce_in_n <= 1'($urandom);
            ews <= 1'($urandom);
            half <= 6'(4 + $urandom % 22);
        end
        chk("rst_hi_o", 1'b0, rst_hi_o);
        wb_xfer(1'b0, STATUS_OFS, 32'h0000_0000, rd);
        chk("status reset", 1'b0, rd[ST_RESET_BIT]);
        chk("status gate", 1'b1, rd[ST_CEPASS_BIT]);
        wb_xfer(1'b0, 8'h0C, 32'h0000_0000, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        wb_xfer(1'b1, CTRL_OFS, 32'h0000_0000, rd);
        run <= 1'b0;
        ce_in_n <= 1'b1;
        repeat (300) @(posedge clk);
        chk("reset_n", 1'b1, reset_n);
        wb_xfer(1'b1, CTRL_OFS, 32'h0000_0001, rd);
        wait_rst(1'b0, 400, n);
        chk_win("watchdog interval", wd_cycles(1'b0, 1'b0), n);
        repeat (2) @(posedge clk);
        chk("fault", 1'b0, fault);
        chk("ce_pullup", 1'b1, ce_pullup);
        wait_rst(1'b1, 200, n);
        chk_win("fault reset pulse", P_RST, n + 2);
        chk("fault", 1'b0, fault);
        wait_rst(1'b0, 400, n);
        chk_win("repeat interval", wd_cycles(1'b1, 1'b0), n);
        timing_lvl <= 1'b0;
        wait_rst(1'b1, 200, n);
        wait_rst(1'b0, 400, n);
        chk_win("first interval", wd_cycles(1'b1, 1'b1), n);
        wait_rst(1'b1, 200, n);
        repeat (10) @(posedge clk);
        half <= 6'h00;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        repeat (5) @(posedge clk);
        chk("fault", 1'b1, fault);
        wait_rst(1'b0, 400, n);
        chk_win("short interval", wd_cycles(1'b0, 1'b1), n + 5);
        kfloat <= 1'b1;
        wait_rst(1'b1, 200, n);
        repeat (400) @(posedge clk);
        chk("reset_n", 1'b1, reset_n);
        chk("fault", 1'b1, fault);
        kfloat <= 1'b0;
        timing_lvl <= 1'b1;
        half <= 6'h06;
        run <= 1'b1;
        ce_in_n <= 1'b0;
        supply_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset_n", 1'b0, reset_n);
        chk("low_line_n", 1'b0, low_line_n);
        repeat (7) @(posedge clk);
        chk("ce_out_n", 1'b0, ce_out_n);
        repeat (750) @(posedge clk);
        chk("ce_out_n", 1'b1, ce_out_n);
        backup <= 1'b1;
        repeat (3) @(posedge clk);
        chk("backup_flag", 1'b1, backup_flag);
        chk("fault", 1'b1, fault);
        supply_low <= 1'b0;
        backup <= 1'b0;
        repeat (3) @(posedge clk);
        chk("low_line_n", 1'b1, low_line_n);
        chk("reset_n", 1'b0, reset_n);
        wait_rst(1'b1, 200, n);
        chk_win("supply stretch", P_RST, n + 3);
        supply_low <= 1'b1;
        repeat (5) @(posedge clk);
        ce_in_n <= 1'b1;
        repeat (2) @(posedge clk);
        ce_in_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("ce_out_n", 1'b1, ce_out_n);
        run <= 1'b0;
        src_strap <= 1'b0;
        ext_run <= 1'b1;
        repeat (4) @(posedge clk);
        supply_low <= 1'b0;
        r0 = rises;
        wait_rst(1'b1, 20000, n);
        chk_win("ext stretch", int'(EXT_RST_CLKS), rises - r0);
        r0 = rises;
        wait_rst(1'b0, 20000, n);
        chk_win("ext first interval", int'(EXT_WD_FIRST_CLKS), rises - r0);
        stop_test();
    end
endmodule : tb_top
